// >>> syc_pkg.sv
// constants for the synchrocheck supervision block
// assumes a 100 MHz clock and Avalon-MM byte addresses
package syc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_CYCLE_MS = 5;
    localparam int PROG_CYCLE_CYC = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIME_STEP_US = 5000;
    localparam int BRK_TIME_MAX_S = 1800;
    localparam int EST_MAX_S = 360;
    localparam logic [23:0] BRK_TIME_MAX = 24'(BRK_TIME_MAX_S * 1000000 / TIME_STEP_US);
    localparam logic [23:0] EST_MAX = 24'(EST_MAX_S * 1000000 / TIME_STEP_US);
    localparam logic [23:0] ROT_NUM = 24'(1000000000 / TIME_STEP_US);
    // est = remaining mdeg * 5 / (9 * |mHz|) in 5 ms steps
    localparam logic [23:0] EST_MUL = 24'h000005;
    localparam logic [23:0] EST_DIV = 24'h000009;
    localparam logic [19:0] FULL_TURN = 20'h57E40;
    localparam logic [19:0] ANG_LIM_SCALE = 20'h0000A;
    localparam logic [4:0] DIV_STEPS = 5'h18;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_REF = 8'h04;
    localparam logic [7:0] OFF_VDIFF = 8'h08;
    localparam logic [7:0] OFF_ADIFF = 8'h0C;
    localparam logic [7:0] OFF_FDIFF = 8'h10;
    localparam logic [7:0] OFF_LIVE = 8'h14;
    localparam logic [7:0] OFF_SWITCH = 8'h18;
    localparam logic [7:0] OFF_BRK = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_EST = 8'h24;
    localparam logic [7:0] OFF_ROT = 8'h28;
    localparam logic [7:0] OFF_ANGLE = 8'h2C;
    localparam int CTRL_FORCE_EN = 0;
    localparam int CTRL_REF_SIDE = 1;
    localparam int CTRL_FORCE_LSB = 4;
    localparam int CTRL_EN_LSB = 8;
    localparam int CTRL_START_LSB = 12;
    localparam int REF2_LSB = 4;
    localparam int REF3_BIT = 8;
    localparam int DEAD_LSB = 16;
    localparam int SW_OBJ_LSB = 4;
    localparam logic [15:0] VDIFF_RST = 16'h00C8;
    localparam logic [15:0] ADIFF_RST = 16'h012C;
    localparam logic [15:0] FDIFF_RST = 16'h0064;
    localparam logic [15:0] LIVE_RST = 16'h07D0;
    localparam logic [15:0] DEAD_RST = 16'h07D0;
    localparam logic [23:0] BRK_RST = 24'h00000A;
    localparam logic [2:0] FORCE_NORMAL = 3'h0;
    localparam logic [2:0] REF1_LAST_RESTRICTED = 3'h3;
    localparam logic [2:0] REF1_LAST = 3'h6;
    localparam logic [2:0] OBJ_LAST = 3'h4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROT = 2'b01,
        ST_EST = 2'b10
    } syc_state_e;
endpackage

// >>> syc_sync_check.sv
// synchrocheck supervision: three stages, forcing on each stage, synchroswitching on stage one
// assumes measurement values come from same-clock logic; block and start inputs are async pins
// How it works
// - blocking inputs are latched at each program-cycle start, one cycle before evaluation
// - each stage is blocked only by its own dedicated block input pin
// - match and no block drives the stage ok output
// - match arriving while blocked sets blocked output and stops further processing
// - a block arriving while ok is set clears ok
// - force selector overrides one stage, default normal, only with force enable
// - reference-side bit picks bus or line as reference, default bus measured
// - per-stage enables reset to off; disabled stages drive no ok or blocked outputs unless forced
// - start-check on-start evaluates only while start input is active; default always
// - stage one reference 0..6, restricted mode allows only 0..3
// - stage two takes references 0..3, available only with both channels in sync mode
// - stage three reference on/off, only in two-line-plus-two-channel mode
// - auto close only on stage one, default off, writable only while enabled
// - auto close issues a close pulse once both sides are synchronized
// - close is advanced by breaker time, 5 ms steps, max 1800 s, default 0.05 s
// - close pulse goes to one of five objects, default first
// - estimated closing time output in 5 ms steps, capped at 360 s
// - full relative rotation time output in 5 ms steps
// - present angle difference output, signed millidegrees
// - settings writes are ignored until a channel is in sync mode
// - match needs magnitude, frequency and angle differences inside limits
// - live above live threshold, dead below dead threshold, both 20 percent
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module syc_sync_check #(
    parameter int PROG_CYCLE_CYC = syc_pkg::PROG_CYCLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [2:0] stage_block_i,
    input wire logic [2:0] stage_start_input_i,
    input wire logic third_voltage_channel_ss_i,
    input wire logic fourth_voltage_channel_ss_i,
    input wire logic restricted_mode_i,
    input wire logic two_line_mode_i,
    input wire logic [2:0][15:0] mag_diff_i,
    input wire logic [2:0][19:0] ang_diff_i,
    input wire logic [2:0][17:0] freq_diff_i,
    input wire logic [2:0][15:0] bus_volt_i,
    input wire logic [2:0][15:0] line_volt_i,
    output logic [2:0] match_ok_output_o,
    output logic [2:0] stage_blocked_o,
    output logic [4:0] close_cmd_o,
    output logic [23:0] est_close_time_o,
    output logic [23:0] rot_time_o,
    output logic [19:0] angle_now_o
);
    function automatic logic [19:0] abs20(input logic [19:0] v);
        abs20 = v[19] ? 20'(-v) : v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    logic [2:0] blk_m_r, blk_s_r, st_m_r, st_s_r, blk_smp_r;
    logic [31:0] tick_cnt_r;
    logic tick_r, eval_r, wait_r;
    logic [31:0] rdata_r, rd_val, wdata;
    logic force_en_r, ref_side_r, auto_close_enable_r, closed_r, cond1_r;
    logic [2:0] force_sel_r, stage_en_r, start_on_r, ref1_r, obj_r;
    logic [1:0] ref2_r;
    logic ref3_r;
    logic [15:0] vlim_r, alim_r, flim_r, live_r, dead_r;
    logic [23:0] brk_r, est_r, rot_r;
    logic [19:0] angle_r;
    logic [2:0] ok_r, blocked_r, raw_r;
    logic [4:0] close_r;
    logic [2:0] avail, active, match, mag_ok, f_ok, volt_ok, ref_used;
    logic [2:0] meas_live, ref_live, meas_dead, ref_dead;
    logic wr_acc, cfg_access;
    syc_pkg::syc_state_e st_r;
    logic [24:0] rem_r, rem_sh;
    logic [23:0] quo_r, den_r, est_num_r;
    logic [4:0] cnt_r;

    // two flops per pin input; only the second stage is read
    always_ff @(posedge clk_i) begin
        blk_m_r <= stage_block_i;
        blk_s_r <= blk_m_r;
        st_m_r <= stage_start_input_i;
        st_s_r <= st_m_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_r <= 32'h00000000;
            tick_r <= 1'b0;
            eval_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == 32'(PROG_CYCLE_CYC - 1));
            tick_cnt_r <= (tick_cnt_r == 32'(PROG_CYCLE_CYC - 1)) ? 32'h00000000 : tick_cnt_r + 32'h00000001;
            eval_r <= tick_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blk_smp_r <= 3'h0;
        end else if (tick_r) begin
            blk_smp_r <= blk_s_r;
        end
    end

    assign cfg_access = third_voltage_channel_ss_i | fourth_voltage_channel_ss_i;
    assign avail[0] = cfg_access;
    assign avail[1] = third_voltage_channel_ss_i & fourth_voltage_channel_ss_i;
    assign avail[2] = avail[1] & two_line_mode_i;
    // an option outside the mode's valid set behaves as not in use
    assign ref_used[0] = (ref1_r != 3'h0) &&
        (ref1_r <= (restricted_mode_i ? syc_pkg::REF1_LAST_RESTRICTED : syc_pkg::REF1_LAST));
    assign ref_used[1] = (ref2_r != 2'h0);
    assign ref_used[2] = ref3_r;

    always_comb begin
        rd_val = 32'h00000000;
        case (avs_address_i)
            syc_pkg::OFF_CTRL: begin
                rd_val[syc_pkg::CTRL_FORCE_EN] = force_en_r;
                rd_val[syc_pkg::CTRL_REF_SIDE] = ref_side_r;
                rd_val[syc_pkg::CTRL_FORCE_LSB +: 3] = force_sel_r;
                rd_val[syc_pkg::CTRL_EN_LSB +: 3] = stage_en_r;
                rd_val[syc_pkg::CTRL_START_LSB +: 3] = start_on_r;
            end
            syc_pkg::OFF_REF: begin
                rd_val[2:0] = ref1_r;
                rd_val[syc_pkg::REF2_LSB +: 2] = ref2_r;
                rd_val[syc_pkg::REF3_BIT] = ref3_r;
            end
            syc_pkg::OFF_VDIFF: rd_val[15:0] = vlim_r;
            syc_pkg::OFF_ADIFF: rd_val[15:0] = alim_r;
            syc_pkg::OFF_FDIFF: rd_val[15:0] = flim_r;
            syc_pkg::OFF_LIVE: rd_val = {dead_r, live_r};
            syc_pkg::OFF_SWITCH: begin
                rd_val[0] = auto_close_enable_r;
                rd_val[syc_pkg::SW_OBJ_LSB +: 3] = obj_r;
            end
            syc_pkg::OFF_BRK: rd_val[23:0] = brk_r;
            syc_pkg::OFF_STATUS: rd_val[15:0] = {1'b0, meas_dead[0], ref_dead[0], ref_live[0], meas_live[0],
                avail, st_r != syc_pkg::ST_IDLE, closed_r, blocked_r, ok_r};
            syc_pkg::OFF_EST: rd_val[23:0] = est_r;
            syc_pkg::OFF_ROT: rd_val[23:0] = rot_r;
            syc_pkg::OFF_ANGLE: rd_val = {{12{angle_r[19]}}, angle_r};
            default: rd_val = 32'h00000000;
        endcase
    end

    // one wait state: waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else begin
            wait_r <= !(wait_r && (avs_read_i || avs_write_i));
            if (wait_r && avs_read_i) begin
                rdata_r <= rd_val;
            end
        end
    end

    assign wr_acc = avs_write_i && !wait_r && cfg_access;
    assign wdata = merge(rd_val, avs_writedata_i, avs_byteenable_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_en_r <= 1'b0;
            ref_side_r <= 1'b0;
            force_sel_r <= syc_pkg::FORCE_NORMAL;
            stage_en_r <= 3'h0;
            start_on_r <= 3'h0;
            ref1_r <= 3'h0;
            ref2_r <= 2'h0;
            ref3_r <= 1'b0;
            vlim_r <= syc_pkg::VDIFF_RST;
            alim_r <= syc_pkg::ADIFF_RST;
            flim_r <= syc_pkg::FDIFF_RST;
            live_r <= syc_pkg::LIVE_RST;
            dead_r <= syc_pkg::DEAD_RST;
            auto_close_enable_r <= 1'b0;
            obj_r <= 3'h0;
            brk_r <= syc_pkg::BRK_RST;
        end else if (wr_acc) begin
            case (avs_address_i)
                syc_pkg::OFF_CTRL: begin
                    force_en_r <= wdata[syc_pkg::CTRL_FORCE_EN];
                    ref_side_r <= wdata[syc_pkg::CTRL_REF_SIDE];
                    force_sel_r <= wdata[syc_pkg::CTRL_FORCE_LSB +: 3];
                    stage_en_r <= wdata[syc_pkg::CTRL_EN_LSB +: 3];
                    start_on_r <= wdata[syc_pkg::CTRL_START_LSB +: 3];
                end
                syc_pkg::OFF_REF: begin
                    ref1_r <= wdata[2:0];
                    ref2_r <= wdata[syc_pkg::REF2_LSB +: 2];
                    ref3_r <= wdata[syc_pkg::REF3_BIT];
                end
                syc_pkg::OFF_VDIFF: vlim_r <= wdata[15:0];
                syc_pkg::OFF_ADIFF: alim_r <= wdata[15:0];
                syc_pkg::OFF_FDIFF: flim_r <= wdata[15:0];
                syc_pkg::OFF_LIVE: begin
                    live_r <= wdata[15:0];
                    dead_r <= wdata[syc_pkg::DEAD_LSB +: 16];
                end
                syc_pkg::OFF_SWITCH: begin
                    if (stage_en_r[0]) begin
                        auto_close_enable_r <= wdata[0];
                        obj_r <= (wdata[syc_pkg::SW_OBJ_LSB +: 3] > syc_pkg::OBJ_LAST) ?
                            syc_pkg::OBJ_LAST : wdata[syc_pkg::SW_OBJ_LSB +: 3];
                    end
                end
                syc_pkg::OFF_BRK: brk_r <= (wdata[23:0] > syc_pkg::BRK_TIME_MAX) ? syc_pkg::BRK_TIME_MAX : wdata[23:0];
                default: begin
                end
            endcase
        end
    end

    generate
        for (genvar i = 0; i < 3; i++) begin : g_stage
            logic [15:0] ms_v, rf_v;
            // reference side swap only affects which voltage is called measured
            assign ms_v = ref_side_r ? line_volt_i[i] : bus_volt_i[i];
            assign rf_v = ref_side_r ? bus_volt_i[i] : line_volt_i[i];
            assign meas_live[i] = ms_v > live_r;
            assign ref_live[i] = rf_v > live_r;
            // a dead threshold of zero disables the dead state
            assign meas_dead[i] = (dead_r != 16'h0000) && (ms_v < dead_r);
            assign ref_dead[i] = (dead_r != 16'h0000) && (rf_v < dead_r);
            assign volt_ok[i] = meas_live[i] & ref_live[i];
            assign mag_ok[i] = abs20({{4{mag_diff_i[i][15]}}, mag_diff_i[i]}) <= {4'h0, vlim_r};
            assign f_ok[i] = abs20({{2{freq_diff_i[i][17]}}, freq_diff_i[i]}) <= {4'h0, flim_r};
            assign active[i] = stage_en_r[i] & avail[i] & ref_used[i] & (!start_on_r[i] | st_s_r[i]);
            assign match[i] = active[i] & volt_ok[i] & mag_ok[i] & f_ok[i] &
                (abs20(ang_diff_i[i]) <= 20'(alim_r) * syc_pkg::ANG_LIM_SCALE);

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    raw_r[i] <= 1'b0;
                    ok_r[i] <= 1'b0;
                    blocked_r[i] <= 1'b0;
                end else if (force_en_r && force_sel_r == 3'(2 * i + 1)) begin
                    // a forced status leaves no history: the next evaluation starts afresh
                    raw_r[i] <= 1'b0;
                    blocked_r[i] <= 1'b1;
                    ok_r[i] <= 1'b0;
                end else if (force_en_r && force_sel_r == 3'(2 * i + 2)) begin
                    raw_r[i] <= 1'b0;
                    blocked_r[i] <= 1'b0;
                    ok_r[i] <= 1'b1;
                end else if (!active[i]) begin
                    raw_r[i] <= 1'b0;
                    ok_r[i] <= 1'b0;
                    blocked_r[i] <= 1'b0;
                end else if (eval_r) begin
                    raw_r[i] <= match[i];
                    if (!match[i]) begin
                        ok_r[i] <= 1'b0;
                        blocked_r[i] <= 1'b0;
                    end else if (!raw_r[i] && blk_smp_r[i]) begin
                        blocked_r[i] <= 1'b1;
                        ok_r[i] <= 1'b0;
                    end else if (blk_smp_r[i]) begin
                        ok_r[i] <= 1'b0;
                    end else if (!raw_r[i] || !blocked_r[i]) begin
                        ok_r[i] <= 1'b1;
                        blocked_r[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // serial divider: one quotient bit per clock, far inside a program cycle
    assign rem_sh = {rem_r[23:0], quo_r[23]};

    always_ff @(posedge clk_i) begin
        logic [19:0] a, f_abs, rem_deg;
        a = ang_diff_i[0];
        f_abs = abs20({{2{freq_diff_i[0][17]}}, freq_diff_i[0]});
        // angle left to travel until the next zero crossing, in slip direction
        if (!freq_diff_i[0][17]) begin
            rem_deg = (a[19] || a == 20'h00000) ? 20'(-a) : 20'(syc_pkg::FULL_TURN - a);
        end else begin
            rem_deg = a[19] ? 20'(syc_pkg::FULL_TURN + a) : a;
        end
        if (rst_i) begin
            st_r <= syc_pkg::ST_IDLE;
            rem_r <= 25'h0000000;
            quo_r <= 24'h000000;
            den_r <= 24'h000000;
            est_num_r <= 24'h000000;
            cnt_r <= 5'h00;
            est_r <= syc_pkg::EST_MAX;
            rot_r <= syc_pkg::EST_MAX;
            angle_r <= 20'h00000;
            cond1_r <= 1'b0;
        end else begin
            if (eval_r) begin
                angle_r <= a;
            end
            case (st_r)
                syc_pkg::ST_IDLE: begin
                    if (eval_r) begin
                        cond1_r <= active[0] & mag_ok[0] & f_ok[0] & volt_ok[0] & !blk_smp_r[0];
                        quo_r <= syc_pkg::ROT_NUM;
                        den_r <= 24'(f_abs);
                        est_num_r <= 24'(rem_deg) * syc_pkg::EST_MUL;
                        rem_r <= 25'h0000000;
                        cnt_r <= syc_pkg::DIV_STEPS;
                        st_r <= syc_pkg::ST_ROT;
                    end
                end
                syc_pkg::ST_ROT, syc_pkg::ST_EST: begin
                    if (cnt_r != 5'h00) begin
                        cnt_r <= cnt_r - 5'h01;
                        if (rem_sh >= {1'b0, den_r}) begin
                            rem_r <= rem_sh - {1'b0, den_r};
                            quo_r <= {quo_r[22:0], 1'b1};
                        end else begin
                            rem_r <= rem_sh;
                            quo_r <= {quo_r[22:0], 1'b0};
                        end
                    end else if (st_r == syc_pkg::ST_ROT) begin
                        // zero slip divides to all ones, which clamps to the maximum
                        rot_r <= (quo_r > syc_pkg::EST_MAX) ? syc_pkg::EST_MAX : quo_r;
                        quo_r <= est_num_r;
                        den_r <= 24'(f_abs) * syc_pkg::EST_DIV;
                        rem_r <= 25'h0000000;
                        cnt_r <= syc_pkg::DIV_STEPS;
                        st_r <= syc_pkg::ST_EST;
                    end else begin
                        est_r <= (quo_r > syc_pkg::EST_MAX) ? syc_pkg::EST_MAX : quo_r;
                        st_r <= syc_pkg::ST_IDLE;
                    end
                end
                default: st_r <= syc_pkg::ST_IDLE;
            endcase
        end
    end

    // close once per synchronized episode; re-armed when the condition drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            close_r <= 5'h00;
            closed_r <= 1'b0;
        end else begin
            close_r <= 5'h00;
            if (st_r == syc_pkg::ST_EST && cnt_r == 5'h00 && auto_close_enable_r && stage_en_r[0] &&
                cond1_r && !closed_r && quo_r <= brk_r) begin
                close_r <= 5'(5'h01 << obj_r);
                closed_r <= 1'b1;
            end else if (eval_r && !(active[0] & volt_ok[0] & mag_ok[0] & f_ok[0])) begin
                closed_r <= 1'b0;
            end
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign match_ok_output_o = ok_r;
    assign stage_blocked_o = blocked_r;
    assign close_cmd_o = close_r;
    assign est_close_time_o = est_r;
    assign rot_time_o = rot_r;
    assign angle_now_o = angle_r;
endmodule

// >>> syc_sync_check_assertions.sv
// port-level checks for the synchrocheck supervision block, bound into every instance
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
module syc_sync_check_assertions #(
    parameter int PROG_CYCLE_CYC = syc_pkg::PROG_CYCLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [2:0] match_ok_output_o,
    input wire logic [2:0] stage_blocked_o,
    input wire logic [4:0] close_cmd_o,
    input wire logic [23:0] est_close_time_o,
    input wire logic [23:0] rot_time_o,
    input wire logic [19:0] angle_now_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property p_bus_answer;
        s_taken |=> s_answer;
    endproperty
    property p_wait_cause;
        !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
    endproperty
    property p_rdata_hold;
        avs_waitrequest_o |-> $stable(avs_readdata_o);
    endproperty
    property p_ok_or_blocked;
        (match_ok_output_o & stage_blocked_o) == 3'h0;
    endproperty
    property p_close_onehot;
        $onehot0(close_cmd_o);
    endproperty
    property p_close_pulse;
        close_cmd_o != 5'h00 |=> close_cmd_o == 5'h00;
    endproperty
    property p_time_cap;
        est_close_time_o <= syc_pkg::EST_MAX && rot_time_o <= syc_pkg::EST_MAX;
    endproperty
    property p_angle_range;
        $signed(angle_now_o) <= 20'sh57E40 && $signed(angle_now_o) >= -20'sh57E40;
    endproperty
    // reset itself is the cause here, so the default disable is switched off
    property p_reset_state;
        disable iff (1'b0) rst_i |=> avs_waitrequest_o && match_ok_output_o == 3'h0 && close_cmd_o == 5'h00;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("request not answered after one wait");
    a_wait_cause: assert property (p_wait_cause) else $error("wait dropped with no request");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside an answer");
    a_ok_or_blocked: assert property (p_ok_or_blocked) else $error("stage ok and blocked together");
    a_close_onehot: assert property (p_close_onehot) else $error("close sent to two objects");
    a_close_pulse: assert property (p_close_pulse) else $error("close longer than one cycle");
    a_time_cap: assert property (p_time_cap) else $error("time output above cap");
    a_angle_range: assert property (p_angle_range) else $error("angle outside a full turn");
    a_reset_state: assert property (p_reset_state) else $error("outputs not idle after reset");
endmodule
bind syc_sync_check syc_sync_check_assertions #(.PROG_CYCLE_CYC(PROG_CYCLE_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .match_ok_output_o(match_ok_output_o), .stage_blocked_o(stage_blocked_o), .close_cmd_o(close_cmd_o),
    .est_close_time_o(est_close_time_o), .rot_time_o(rot_time_o), .angle_now_o(angle_now_o));

// >>> syc_partner_model.sv
// blocking matrix and breaker objects on the far side of the block
// assumes the bench sets block levels; close pulses are latched until reset
`timescale 1ns/1ns
module syc_partner_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] blk_req_i,
    input wire logic [4:0] close_cmd_i,
    output logic [2:0] stage_block_o,
    output logic [4:0] close_seen_o
);
    // one dedicated block line per stage, no sharing between stages
    assign stage_block_o = blk_req_i;
    // a one-cycle close pulse would be missed by a slow poll, so it is held
    always_ff @(posedge clk_i) begin
        if (rst_i)
            close_seen_o <= 5'h00;
        else
            close_seen_o <= close_seen_o | close_cmd_i;
    end
endmodule

// >>> test_synchrocheck_block_and_switching.sv
// self-checking bench for the synchrocheck supervision block
// assumes the partner model and the bound checker are compiled alongside
`timescale 1ns/1ns
module test_synchrocheck_block_and_switching;
    localparam int PC = 64;
    logic clk_i, rst_i, rd, wq, wt, c3, c4, rm, tm;
    logic [7:0] adr;
    logic [31:0] wd, rdat, q;
    logic [3:0] be;
    logic [2:0] breq, blk, st, ok, bl;
    logic [4:0] cls, seen;
    logic [23:0] est, rot;
    logic [19:0] angn;
    logic [2:0][15:0] mag, vb, vl;
    logic [2:0][19:0] ang;
    logic [2:0][17:0] frq;
    int err_total, check_count;
    logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h30};
    logic [31:0] rv [9] = '{32'h0, 32'h0, 32'hC8, 32'h12C, 32'h64, 32'h07D007D0, 32'h0, 32'hA, 32'h0};
    syc_sync_check #(.PROG_CYCLE_CYC(PC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wq), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .stage_block_i(blk), .stage_start_input_i(st),
        .third_voltage_channel_ss_i(c3), .fourth_voltage_channel_ss_i(c4), .restricted_mode_i(rm),
        .two_line_mode_i(tm), .mag_diff_i(mag), .ang_diff_i(ang), .freq_diff_i(frq), .bus_volt_i(vb),
        .line_volt_i(vl), .match_ok_output_o(ok), .stage_blocked_o(bl), .close_cmd_o(cls),
        .est_close_time_o(est), .rot_time_o(rot), .angle_now_o(angn));
    syc_partner_model u_far (.clk_i(clk_i), .rst_i(rst_i), .blk_req_i(breq), .close_cmd_i(cls),
        .stage_block_o(blk), .close_seen_o(seen));
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        rd <= !w;
        wq <= w;
        do begin
            @(posedge clk_i);
        end while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wq <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic cyc(input int n);
        repeat (n * PC) @(posedge clk_i);
    endtask
    task automatic outs(input logic [5:0] e);
        chk({26'h0, bl, ok}, {26'h0, e});
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        close_out();
    end
    initial begin
        {err_total, check_count} = '0;
        {rst_i, rd, wq, c3, c4, rm, tm, adr, wd, breq, st} = {1'b1, 5'h0, 1'b1, 8'h0, 32'h0, 6'h0};
        be = 4'hF;
        mag = '0;
        vb = {3{16'h2710}};
        vl = {3{16'h2710}};
        ang = {3{20'h003E8}};
        frq = {3{18'h00032}};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) rdc(ra[i], rv[i]);
        bus(1'b1, 8'h00, 32'h700);
        rdc(8'h00, 32'h0);
        c3 <= 1'b1;
        c4 <= 1'b1;
        bus(1'b1, 8'h18, 32'h21);
        rdc(8'h18, 32'h0);
        bus(1'b1, 8'h00, 32'h700);
        bus(1'b1, 8'h04, 32'h111);
        bus(1'b1, 8'h1C, 32'h57E40);
        bus(1'b1, 8'h18, 32'h21);
        rdc(8'h18, 32'h21);
        cyc(3);
        outs(6'h07);
        rdc(8'h28, 32'hFA0);
        chk({8'h0, rot}, 32'hFA0);
        chk({8'h0, est}, 32'hF94);
        chk({12'h0, angn}, 32'h3E8);
        chk({27'h0, seen}, 32'h4);
        breq <= 3'h1;
        cyc(2);
        outs(6'h06);
        ang[0] <= 20'h02710;
        cyc(2);
        outs(6'h06);
        ang[0] <= 20'h003E8;
        cyc(2);
        outs(6'h0E);
        ang[0] <= 20'h02710;
        breq <= 3'h0;
        cyc(2);
        ang[0] <= 20'h003E8;
        bus(1'b1, 8'h00, 32'h1700);
        cyc(2);
        outs(6'h06);
        st <= 3'h1;
        cyc(2);
        outs(6'h07);
        bus(1'b1, 8'h00, 32'h1711);
        cyc(1);
        outs(6'h0E);
        bus(1'b1, 8'h00, 32'h1710);
        cyc(2);
        outs(6'h07);
        bus(1'b1, 8'h00, 32'h1751);
        cyc(1);
        outs(6'h23);
        bus(1'b1, 8'h00, 32'h1700);
        rm <= 1'b1;
        bus(1'b1, 8'h04, 32'h114);
        cyc(2);
        outs(6'h06);
        {rm, c4, tm} <= 3'h0;
        cyc(2);
        outs(6'h01);
        bus(1'b1, 8'h00, 32'h0);
        cyc(1);
        outs(6'h00);
        close_out();
    end
endmodule
